// File: design/ssp_params.svh
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// register byte offsets on the bus
`define SSP_OFF_STAT    12'h000
`define SSP_OFF_CON1    12'h004
`define SSP_OFF_BUF     12'h008
`define SSP_OFF_FLAG    12'h00C
// status bit positions
`define SSP_STAT_SMP    7
`define SSP_STAT_CKE    6
`define SSP_STAT_STOP   4
`define SSP_STAT_BF     0
// control bit positions
`define SSP_CON_WRITE_COLLISION    7
`define SSP_CON_OV      6
`define SSP_CON_EN      5
`define SSP_CON_CKP     4
// reset values
`define SSP_STAT_RST    8'h00
`define SSP_CON1_RST    8'h00
// frame length and master dividers in system clocks per half bit
`define SSP_FRAME_BITS  4'h8
`define SSP_HALF_DIV4   8'h02
`define SSP_HALF_DIV16  8'h08
`define SSP_HALF_DIV64  8'h20
`endif

// File: design/ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [3:0] {
    SSP_M_DIV4   = 4'h0,
    SSP_M_DIV16  = 4'h1,
    SSP_M_DIV64  = 4'h2,
    SSP_M_TIMER_TWO   = 4'h3,
    SSP_M_SLV_SS = 4'h4,
    SSP_M_SLV    = 4'h5
  } ssp_mode_t;
  typedef enum logic [2:0] {
    SSP_IDLE  = 3'b001,
    SSP_SHIFT = 3'b010,
    SSP_DONE  = 3'b100
  } ssp_state_t;
  typedef struct packed {
    logic sck;
    logic sdo;
    logic sdoEn;
    logic sckEn;
  } ssp_pins_t;
endpackage

// File: design/ssp_serial_port.sv
`timescale 1ns/1ns
`include "ssp_params.svh"
module ssp_serial_port
  import ssp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timerTwoOut,
  input  wire logic        sckIn,
  input  wire logic        sdiIn,
  input  wire logic        ssIn,
  output logic             sckOut,
  output logic             sckOe,
  output logic             sdoOut,
  output logic             sdoOe,
  output logic             portIntFlag,
  output logic             pinsOwned
);
  // bus decode, one wait-free access phase
  logic access;
  logic wrEn;
  logic rdEn;
  logic hitStat;
  logic hitCon;
  logic hitBuf;
  logic hitFlag;
  logic mapped;
  assign access  = psel & penable & clkEn;
  assign wrEn    = access & pwrite;
  assign rdEn    = access & ~pwrite;
  assign hitStat = paddr == `SSP_OFF_STAT;
  assign hitCon  = paddr == `SSP_OFF_CON1;
  assign hitBuf  = paddr == `SSP_OFF_BUF;
  assign hitFlag = paddr == `SSP_OFF_FLAG;
  assign mapped  = hitStat | hitCon | hitBuf | hitFlag;

  logic [7:0] stat_r;
  logic [7:0] con_r;
  logic [7:0] buf_r;
  logic [7:0] shift_r;
  logic [3:0] bitCnt_r;
  logic       flag_r;
  ssp_state_t state_r;
  ssp_state_t state_nxt;

  // mode decode
  ssp_mode_t mode;
  logic      enabled;
  logic      isMaster;
  logic      isSlave;
  logic      useSs;
  assign mode     = ssp_mode_t'(con_r[3:0]);
  assign enabled  = con_r[`SSP_CON_EN];
  assign isMaster = enabled & (con_r[3:2] == 2'b00);
  assign isSlave  = enabled & (con_r[3:1] == 3'b010);
  assign useSs    = isSlave & ~con_r[0];
  logic clock_polarity;
  logic cke;
  logic sample_phase;
  assign clock_polarity = con_r[`SSP_CON_CKP];
  assign cke = stat_r[`SSP_STAT_CKE];
  assign sample_phase = stat_r[`SSP_STAT_SMP] & isMaster;

  // pin synchronisers, two flops each before any use
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic [2:0] syncC_r;
  logic       sckSeen;
  logic       sdiS;
  logic       ssS;
  logic       sckPrev_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncA_r <= 3'b000;
      syncB_r <= 3'b000;
      syncC_r <= 3'b000;
    end else if (clkEn) begin
      syncA_r <= {sckIn, sdiIn, ssIn};
      syncB_r <= syncA_r;
      // timer input gets its own two stages plus an edge-history stage
      syncC_r <= {syncC_r[1:0], timerTwoOut};
    end
  end
  assign sckSeen = syncB_r[2];
  assign sdiS    = syncB_r[1];
  assign ssS     = syncB_r[0];

  // master bit timing: half-period counter and timer two edges
  logic [7:0] halfDiv;
  logic [7:0] divCnt_r;
  logic       tick;
  logic       tmrRise;
  assign halfDiv = (mode == SSP_M_DIV16) ? `SSP_HALF_DIV16 :
                   (mode == SSP_M_DIV64) ? `SSP_HALF_DIV64 :
                   `SSP_HALF_DIV4;
  assign tmrRise = syncC_r[1] & ~syncC_r[2];
  assign tick = (mode == SSP_M_TIMER_TWO) ? tmrRise :
                (divCnt_r == halfDiv - 8'h01);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divCnt_r  <= 8'h00;
      sckPrev_r <= 1'b0;
    end else if (clkEn) begin
      sckPrev_r <= sckSeen;
      divCnt_r  <= (tick || state_r != SSP_SHIFT) ? 8'h00
                                                  : divCnt_r + 8'h01;
    end
  end

  // serial clock phase: leading edge leaves idle, trailing returns
  logic phase_r;
  logic leadEdge;
  logic trailEdge;
  logic slvLead;
  logic slvTrail;
  logic sckRise;
  logic sckFall;
  assign sckRise  = sckSeen & ~sckPrev_r;
  assign sckFall  = ~sckSeen & sckPrev_r;
  assign slvLead  = clock_polarity ? sckFall : sckRise;
  assign slvTrail = clock_polarity ? sckRise : sckFall;
  assign leadEdge  = isMaster ? (tick & ~phase_r) : slvLead;
  assign trailEdge = isMaster ? (tick & phase_r) : slvTrail;

  // data out changes on one edge; input latched on the other, or on the same edge when SMP is set in master mode
  logic shiftEdge;
  logic sampleEdge;
  logic ssBlock;
  assign ssBlock    = useSs & ssS;
  assign shiftEdge  = cke ? trailEdge : leadEdge;
  assign sampleEdge = (cke ^ sample_phase) ? leadEdge : trailEdge;

  // buffer write and frame end
  logic bufWr;
  logic bufRd;
  logic busy;
  logic startWr;
  logic frameEnd;
  logic lastShift;
  assign busy      = state_r != SSP_IDLE;
  assign bufWr     = wrEn & hitBuf;
  assign bufRd     = rdEn & hitBuf;
  assign startWr   = bufWr & ~busy & (isMaster | isSlave);
  assign lastShift = bitCnt_r == `SSP_FRAME_BITS - 4'h1;
  assign frameEnd  = state_r == SSP_DONE;

  // frame sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSP_IDLE: begin
        if (startWr & isMaster) begin
          state_nxt = SSP_SHIFT;
        end else if (isSlave & ~ssBlock & (slvLead | slvTrail)) begin
          state_nxt = SSP_SHIFT;
        end
      end
      SSP_SHIFT: begin
        if (!enabled || ssBlock) begin
          state_nxt = SSP_IDLE;
        end else if (lastShift && sampleEdge && !cke) begin
          state_nxt = SSP_DONE;
        end else if (bitCnt_r == `SSP_FRAME_BITS && shiftEdge) begin
          // wait for the last shift so the eighth bit is in the register
          state_nxt = SSP_DONE;
        end
      end
      SSP_DONE: begin
        state_nxt = SSP_IDLE;
      end
      default: begin
        state_nxt = SSP_IDLE;
      end
    endcase
  end

  // shift register: sample into lsb, send from msb
  logic       sampled_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r   <= SSP_IDLE;
      shift_r   <= 8'h00;
      bitCnt_r  <= 4'h0;
      phase_r   <= 1'b0;
      sampled_r <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      if (startWr) begin
        shift_r <= pwdata[7:0];
      end else if (state_r == SSP_SHIFT || state_nxt == SSP_SHIFT) begin
        if (sampleEdge) begin
          sampled_r <= sdiS;
          bitCnt_r  <= bitCnt_r + 4'h1;
        end
        if (shiftEdge && bitCnt_r != 4'h0) begin
          shift_r <= {shift_r[6:0], sampled_r};
        end
      end
      if (tick && state_r == SSP_SHIFT) begin
        phase_r <= ~phase_r;
      end
      if ((state_r == SSP_IDLE && state_nxt != SSP_SHIFT) || ssBlock ||
          !enabled) begin
        bitCnt_r <= 4'h0;
        phase_r  <= 1'b0;
      end
    end
  end

  // received byte; with CKE clear the last sampled bit is appended, with CKE set it is the shift register
  logic [7:0] rxByte;
  assign rxByte = cke ? shift_r : {shift_r[6:0], sampled_r};

  // registers and sticky flags, hardware set wins over clear
  logic ovSet;
  logic wcolSet;
  assign wcolSet = bufWr & busy;
  assign ovSet   = frameEnd & isSlave & stat_r[`SSP_STAT_BF];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat_r <= `SSP_STAT_RST;
      con_r  <= `SSP_CON1_RST;
      buf_r  <= 8'h00;
      flag_r <= 1'b0;
    end else if (clkEn) begin
      if (wrEn && hitCon) begin
        con_r <= pwdata[7:0];
      end
      if (wrEn && hitStat) begin
        stat_r[7:6] <= pwdata[7:6];
      end
      if (isSlave) begin
        stat_r[`SSP_STAT_SMP] <= 1'b0;
      end
      if (startWr) begin
        buf_r <= pwdata[7:0];
      end
      if (bufRd) begin
        stat_r[`SSP_STAT_BF] <= 1'b0;
      end
      if (wrEn && hitFlag && pwdata[0]) begin
        flag_r <= 1'b0;
      end
      if (frameEnd && !ovSet) begin
        buf_r                <= rxByte;
        stat_r[`SSP_STAT_BF] <= 1'b1;
      end
      if (frameEnd) begin
        flag_r <= 1'b1;
      end
      if (ovSet) begin
        con_r[`SSP_CON_OV] <= 1'b1;
      end
      if (wcolSet) begin
        con_r[`SSP_CON_WRITE_COLLISION] <= 1'b1;
      end
      if (!enabled) begin
        stat_r[`SSP_STAT_STOP] <= 1'b0;
      end
    end
  end

  // read mux and answer, zero wait states
  logic [7:0] rdSel;
  assign rdSel = hitStat ? stat_r :
                 hitCon  ? con_r :
                 hitBuf  ? buf_r :
                 hitFlag ? {7'h00, flag_r} : 8'h00;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= {24'h00_0000, rdSel};
    end
  end

  // pin drive, registered; instance keeps its own pins
  logic sckLvl;
  assign sckLvl = (state_r == SSP_SHIFT) ? (clock_polarity ^ phase_r) : clock_polarity;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sckOut      <= 1'b0;
      sckOe       <= 1'b0;
      sdoOut      <= 1'b0;
      sdoOe       <= 1'b0;
      portIntFlag <= 1'b0;
      pinsOwned   <= 1'b0;
    end else if (clkEn) begin
      sckOut      <= sckLvl;
      sckOe       <= isMaster;
      sdoOut      <= shift_r[7];
      sdoOe       <= isMaster | (isSlave & ~ssBlock);
      portIntFlag <= flag_r;
      pinsOwned   <= enabled;
    end
  end

  // checks
  AST_WRITE_COLLISION_STICKY: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && wcolSet |=> con_r[`SSP_CON_WRITE_COLLISION])
    else $error("write collision not flagged");
  AST_NO_OV_MASTER: assert property (@(posedge clk_sys) disable iff (rst)
    isMaster && $stable(con_r) |-> !$rose(con_r[`SSP_CON_OV]))
    else $error("overflow set in master mode");
  AST_BF_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && bufRd && !frameEnd |=> !stat_r[`SSP_STAT_BF])
    else $error("buffer full not cleared");
  AST_FRAME_BF: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && frameEnd |=> stat_r[`SSP_STAT_BF] && flag_r)
    else $error("frame end did not fill buffer");
  AST_SS_FLOAT: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && ssBlock |=> !sdoOe)
    else $error("data out driven while deselected");
  AST_SCK_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && state_r == SSP_IDLE |=> sckOut == $past(clock_polarity))
    else $error("clock idle level wrong");
  AST_SMP_SLAVE: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && isSlave |=> !stat_r[`SSP_STAT_SMP])
    else $error("sample phase active in slave");
  AST_STOP_OFF: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !enabled |=> !stat_r[`SSP_STAT_STOP])
    else $error("stop bit not cleared");
endmodule

// File: verif/ssp_spi_partner.sv
`timescale 1ns/1ns
// far-side peripheral in clock mode 0,0: samples and shifts on the rise;
// the master samples before its own clock pin moves, so the next bit
// must start early to get through the input synchroniser in time
module ssp_spi_partner (
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic       load,
  input  wire logic [7:0] txByte,
  output logic            sdi,
  output logic      [7:0] rxByte
);
  logic [7:0] txSh;

  // refill feeds inverted bits so a stale line never reads as valid data
  always @(posedge load) txSh = txByte;
  always @(posedge sck) txSh = {txSh[6:0], ~txSh[0]};
  always @(posedge sck) rxByte = {rxByte[6:0], sdo};
  assign sdi = txSh[7];
endmodule

// File: verif/tb_ssp_serial_port.sv
`timescale 1ns/1ns
module tb_ssp_serial_port;
  import ssp_pkg::*;
  logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        timerTwoOut = 0, slv = 0, bSck = 0, bSdi = 0, ssIn = 0;
  logic        load = 0, err, pready, pslverr, sckOut, sckOe, sdoOut;
  logic        sdoOe, portIntFlag, pinsOwned, partSdi;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0]  pTx = 0, pRx, b, c;
  int          errors = 0, samples_checked = 0, seed = 81, cyc = 0;
  wire         sckIn = slv ? bSck : sckOut;
  wire         sdiIn = slv ? bSdi : partSdi;

  ssp_serial_port dut_u (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerTwoOut(timerTwoOut), .sckIn(sckIn), .sdiIn(sdiIn), .ssIn(ssIn),
    .sckOut(sckOut), .sckOe(sckOe), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .portIntFlag(portIntFlag), .pinsOwned(pinsOwned));
  ssp_spi_partner partner_u (.sck(sckOut), .sdo(sdoOut), .load(load),
    .txByte(pTx), .sdi(partSdi), .rxByte(pRx));

  always #2 clk_sys = ~clk_sys;
  // timer tick source and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    timerTwoOut <= cyc[1];
    if (cyc > 40000) begin
      errors++;
      tally_and_finish();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // link clock 32 ns, data set while low, sampled on the fall
  task sframe(input logic [7:0] v, input int n);
    #1;
    for (int i = 7; i > 7 - n; i--) begin
      bSdi = v[i]; #8 bSck = 1; #16 bSck = 0; #8;
    end
    repeat (6) @(posedge clk_sys);
  endtask

  // pin outputs are registered one edge after the register write
  task settle();
    @(posedge clk_sys);
    #1;
  endtask

  task tally_and_finish();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    apb(0, 12'h000, 0); chk(rd, 8'h00);
    apb(0, 12'h004, 0); chk(rd, 8'h00);
    apb(0, 12'h010, 0); chk(err, 1);
    apb(1, 12'h000, 8'hFF); apb(0, 12'h000, 0); chk(rd, 8'hC0);
    apb(1, 12'h000, 8'h40);
    // every master rate, with a write colliding into each frame
    for (int m = 0; m < 4; m++) begin
      apb(1, 12'h004, 8'h20 | m); settle();
      chk(pinsOwned, 1);
      chk(sckOe, 1);
      b = 8'($random(seed)); pTx = 8'($random(seed));
      load <= 1; @(posedge clk_sys) load <= 0;
      apb(1, 12'h008, b); apb(1, 12'h008, ~b);
      while (portIntFlag !== 1'b1 && cyc < 30000) @(posedge clk_sys);
      chk(portIntFlag, 1);
      apb(0, 12'h004, 0); chk(rd, 8'hA0 | m);
      apb(0, 12'h000, 0); chk(rd, 8'h41);
      apb(0, 12'h008, 0); chk(rd, pTx);
      chk(pRx, b);
      apb(0, 12'h000, 0); chk(rd, 8'h40);
      apb(1, 12'h00C, 1); apb(1, 12'h004, 8'h20 | m);
      apb(0, 12'h004, 0); chk(rd, 8'h20 | m);
    end
    apb(1, 12'h004, 8'h30); settle(); chk(sckOut, 1);
    apb(1, 12'h004, 8'h20); settle(); chk(sckOut, 0);
    apb(1, 12'h004, 0); settle(); chk(pinsOwned, 0);
    chk(sckOe, 0);
    // slave without select: second unread frame overflows
    slv <= 1; ssIn <= 1;
    apb(1, 12'h000, 0); apb(1, 12'h004, 8'h25); settle();
    chk(sckOe, 0);
    chk(sdoOe, 1);
    b = 8'($random(seed));
    sframe(b, 8); sframe(~b, 8);
    apb(0, 12'h004, 0); chk(rd, 8'h65);
    apb(0, 12'h008, 0); chk(rd, b);
    apb(1, 12'h000, 8'h80); apb(0, 12'h000, 0); chk(rd, 0);
    // slave with select: select high floats output and restarts count
    apb(1, 12'h004, 8'h24); repeat (4) @(posedge clk_sys);
    chk(sdoOe, 0);
    ssIn <= 0; repeat (4) @(posedge clk_sys);
    chk(sdoOe, 1);
    c = 8'($random(seed));
    sframe(~c, 4); ssIn <= 1; repeat (4) @(posedge clk_sys);
    ssIn <= 0; repeat (4) @(posedge clk_sys);
    sframe(c, 8);
    apb(0, 12'h008, 0); chk(rd, c);
    apb(1, 12'h004, 8'h27); settle(); chk(sdoOe, 0);
    chk(sckOe, 0);
    tally_and_finish();
  end
endmodule
